// *** verif/fifo_load_model.sv ***
// Downstream load pulse monitor standing on the status pins
`timescale 1ns/100ps
`default_nettype none
module fifo_load_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pins from the block
  input wire logic strobe_n,
  input wire logic oe_n,
  // Observations
  output logic [7:0] n_loads,
  output logic wide_pulse
);
  logic prev_n;
  // Counts low pulses, flags any wider than one clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_loads <= 8'h00;
      wide_pulse <= 1'b0;
      prev_n <= 1'b1;
    end else if (!oe_n) begin
      prev_n <= strobe_n;
      if (!strobe_n && prev_n) begin
        n_loads <= n_loads + 8'h01;
      end
      if (!strobe_n && !prev_n) begin
        wide_pulse <= 1'b1;
      end
    end
  end
endmodule : fifo_load_model
`default_nettype wire

// *** verif/tb_video_timing_status_outputs.sv ***
// Self-checking bench for the video timing status outputs
`timescale 1ns/100ps
`default_nettype none
module tb_video_timing_status_outputs;
  import vid_status_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, out_oe_n, irq, wide;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] err_event;
  logic [7:0] n_loads;
  vid_word_type vin;
  status_out_type so;
  int n_errors, comparisons;
  assign hready = hreadyout;
  vid_status_out i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .vin(vin),
    .err_event(err_event), .status_out(so), .out_oe_n(out_oe_n), .irq(irq));
  fifo_load_model i_fifo (.hclk(hclk), .hresetn(hresetn), .strobe_n(so.buffer_load_strobe_n),
    .oe_n(out_oe_n), .n_loads(n_loads), .wide_pulse(wide));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  function automatic logic [9:0] xyz(input logic f, input logic v, input logic h);
    return {1'b1, f, v, h, 6'h00};
  endfunction : xyz
  task automatic send_trs(input logic [9:0] x);
    logic [9:0] w[4];
    w = '{TRS_PRE1, TRS_PRE0, TRS_PRE0, x};
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      vin <= '{1'b1, w[i]};
    end
    @(posedge hclk);
    vin.valid <= 1'b0;
    #1;
  endtask : send_trs
  task automatic send_data(input int n);
    repeat (n) begin
      @(posedge hclk);
      vin <= '{1'b1, 10'h200};
    end
    @(posedge hclk);
    vin.valid <= 1'b0;
    #1;
  endtask : send_data
  task automatic pulse_err(input logic [4:0] e);
    @(posedge hclk);
    err_event <= e;
    @(posedge hclk);
    err_event <= 5'h00;
    #1;
  endtask : pulse_err
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    xfer(1'b0, ERR_ENABLE_OFS, 0); chk(rd, 32'h1f);
    xfer(1'b0, IO_CTRL_OFS, 0); chk(rd, 32'h0);
    xfer(1'b0, INT_MASK_OFS, 0); chk(rd, 32'h0);
    xfer(1'b0, 8'h40, 0); chk(rd, 32'h0);
    chk({hreadyout, hresp}, 2'h2);
    xfer(1'b0, TIMING_OFS, 0); chk(rd, 32'h18);
    $display("test regs done");
  endtask : t_regs
  task automatic t_field;
    send_trs(xyz(1, 1, 1)); chk({so.field_odd_even, so.vblank, so.hblank}, 3'h7);
    send_trs(xyz(1, 1, 0)); chk(so.buffer_load_strobe_n, 1'b0);
    chk(so.hblank, 1'b1);
    @(posedge hclk); #1 chk(so.buffer_load_strobe_n, 1'b1);
    send_data(2); chk(so.hblank, 1'b1);
    send_data(2); chk(so.hblank, 1'b0);
    send_trs(xyz(0, 0, 1)); chk({so.field_odd_even, so.vblank}, 2'h0);
    chk({wide, n_loads}, 9'h001);
    $display("test field done");
  endtask : t_field
  task automatic t_hstyle;
    xfer(1'b1, IO_CTRL_OFS, 32'h1);
    send_trs(xyz(0, 0, 1)); chk(so.hblank, 1'b1);
    send_trs(xyz(0, 0, 0)); chk(so.hblank, 1'b0);
    xfer(1'b1, IO_CTRL_OFS, 32'h0);
    $display("test hstyle done");
  endtask : t_hstyle
  task automatic t_err;
    #1 chk(so.stream_err_n, 1'b1);
    pulse_err(5'h04); chk(so.stream_err_n, 1'b0);
    repeat (3) @(posedge hclk);
    #1 chk(so.stream_err_n, 1'b0);
    xfer(1'b0, ERR_STATUS_OFS, 0); chk(rd, 32'h04);
    #1 chk(so.stream_err_n, 1'b1);
    pulse_err(5'h10); send_trs(xyz(0, 1, 1)); chk(so.stream_err_n, 1'b1);
    xfer(1'b1, ERR_ENABLE_OFS, 32'h1e);
    pulse_err(5'h01); chk(so.stream_err_n, 1'b1);
    xfer(1'b1, ERR_ENABLE_OFS, 32'h1f);
    xfer(1'b0, ERR_STATUS_OFS, 0);
    xfer(1'b0, INT_STATUS_OFS, 0);
    xfer(1'b1, INT_MASK_OFS, 32'h1);
    pulse_err(5'h02); #1 chk(irq, 1'b1);
    xfer(1'b0, INT_STATUS_OFS, 0); #1 chk(irq, 1'b0);
    xfer(1'b1, INT_MASK_OFS, 32'h0);
    pulse_err(5'h02); #1 chk(irq, 1'b0);
    $display("test err done");
  endtask : t_err
  task automatic t_reset;
    xfer(1'b1, IO_CTRL_OFS, 32'h1);
    xfer(1'b1, ERR_ENABLE_OFS, 32'h3);
    #1 chk(so.stream_err_n, 1'b0);
    @(posedge hclk);
    hresetn <= 1'b0;
    #1 chk({out_oe_n, so}, 6'h38);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1 chk(out_oe_n, 1'b0);
    xfer(1'b0, IO_CTRL_OFS, 0); chk(rd, 32'h0);
    xfer(1'b0, ERR_ENABLE_OFS, 0); chk(rd, {27'h0, ERR_ENABLE_RST});
    xfer(1'b1, INT_MASK_OFS, 32'h6);
    send_trs(xyz(0, 1, 1)); chk(irq, 1'b1);
    xfer(1'b0, INT_STATUS_OFS, 0); chk(rd, 32'h2);
    send_trs(xyz(0, 1, 0)); chk(so.buffer_load_strobe_n, 1'b0);
    xfer(1'b0, INT_STATUS_OFS, 0); chk(rd, 32'h4);
    $display("test reset done");
  endtask : t_reset
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, err_event} = '0;
    hsize = 3'h2;
    vin = '{1'b0, 10'h000};
    repeat (12) @(posedge hclk);
    chk({out_oe_n, so}, 6'h38);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    #1 chk(out_oe_n, 1'b0);
    t_regs();
    t_field();
    t_hstyle();
    t_err();
    t_reset();
    finish_test();
  end
endmodule : tb_video_timing_status_outputs
`default_nettype wire

// *** verilog/vid_status_out.sv ***
// Video timing status outputs with an AHB-Lite register slave
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module vid_status_out (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Received video words and error detector events
  input wire vid_status_pkg::vid_word_type vin,
  input wire logic [vid_status_pkg::ERR_W-1:0] err_event,
  // Status and timing outputs
  output var vid_status_pkg::status_out_type status_out,
  output logic out_oe_n,
  // Interrupt
  output logic irq
);
  import vid_status_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_type s_r;
  state_type s_nxt;
  logic addr_phase;
  logic rd_hit;
  logic err_rd_clr;
  logic int_rd_clr;
  logic trs_hit;
  logic trs_eav;
  logic trs_sav;
  logic field_start;
  logic err_new;
  logic [ERR_W-1:0] err_set;
  logic [INT_W-1:0] int_set;
  logic [31:0] rd_val;
  logic err_clr;
  logic [ERR_W-1:0] err_sticky_nxt;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign addr_phase = hsel & hready & htrans[1];
  assign rd_hit = addr_phase & ~hwrite;
  assign err_rd_clr = rd_hit & (haddr[7:0] == ERR_STATUS_OFS) & (haddr[31:8] == 24'h000000);
  assign int_rd_clr = rd_hit & (haddr[7:0] == INT_STATUS_OFS) & (haddr[31:8] == 24'h000000);

  always_comb begin
    rd_val = 32'h00000000;
    if (haddr[31:8] != 24'h000000) begin
      rd_val = 32'h00000000;
    end else if (haddr[7:0] == ERR_STATUS_OFS) begin
      rd_val[ERR_W-1:0] = s_r.err_status;
    end else if (haddr[7:0] == ERR_ENABLE_OFS) begin
      rd_val[ERR_W-1:0] = s_r.err_enable;
    end else if (haddr[7:0] == IO_CTRL_OFS) begin
      rd_val[H_STYLE_BIT] = s_r.h_style;
    end else if (haddr[7:0] == INT_STATUS_OFS) begin
      rd_val[INT_W-1:0] = s_r.int_status;
    end else if (haddr[7:0] == INT_MASK_OFS) begin
      rd_val[INT_W-1:0] = s_r.int_mask;
    end else if (haddr[7:0] == TIMING_OFS) begin
      rd_val[4:0] = s_r.outs;
    end
  end

  // ----------------------------------------------------------------
  // Timing reference detection
  // ----------------------------------------------------------------
  // Pattern 3ff 000 000 xyz; w3 holds 3ff, outputs take f, v and h from the incoming word xyz
  assign trs_hit = vin.valid & (s_r.w3 == TRS_PRE1) & (s_r.w2 == TRS_PRE0)
                   & (s_r.w1 == TRS_PRE0);
  assign trs_eav = trs_hit & vin.data[XYZ_H_BIT];
  assign trs_sav = trs_hit & ~vin.data[XYZ_H_BIT];
  // New field or frame: vertical bit rising
  assign field_start = trs_hit & vin.data[XYZ_V_BIT] & ~s_r.v;
  assign err_set = err_event;
  assign err_new = |(err_event & s_r.err_enable);
  assign int_set = {trs_sav, field_start, err_new};

  // ----------------------------------------------------------------
  // Sticky error bits
  // ----------------------------------------------------------------
  // Clears on field start or status read; a new event wins
  assign err_clr = field_start | err_rd_clr;
  for (genvar gi = 0; gi < ERR_W; gi++) begin : g_err_bit
    assign err_sticky_nxt[gi] = err_set[gi] | (s_r.err_status[gi] & ~err_clr);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.out_oe_n = 1'b0;
    if (vin.valid) begin
      s_nxt.w1 = vin.data;
      s_nxt.w2 = s_r.w1;
      s_nxt.w3 = s_r.w2;
      if (trs_hit) begin
        s_nxt.f = vin.data[XYZ_F_BIT];
        s_nxt.v = vin.data[XYZ_V_BIT];
        s_nxt.h_bit = vin.data[XYZ_H_BIT];
      end
      if (trs_eav) begin
        s_nxt.h_blank = 1'b1;
        s_nxt.sav_cnt = 2'h0;
      end else if (trs_sav) begin
        s_nxt.h_blank = 1'b1;
        s_nxt.sav_cnt = SAV_TAIL;
      end else if (s_r.sav_cnt != 2'h0) begin
        s_nxt.sav_cnt = s_r.sav_cnt - 2'h1;
      end else if (!s_r.h_bit) begin
        s_nxt.h_blank = 1'b0;
      end
    end
    // Per-condition sticky bits from the loop above
    s_nxt.err_status = err_sticky_nxt;
    if (int_rd_clr) begin
      s_nxt.int_status = int_set;
    end else begin
      s_nxt.int_status = s_r.int_status | int_set;
    end
    s_nxt.dph_wr = addr_phase & hwrite & (haddr[31:8] == 24'h000000);
    s_nxt.dph_addr = haddr[7:0];
    if (rd_hit) begin
      s_nxt.hrdata = rd_val;
    end
    if (s_r.dph_wr) begin
      if (s_r.dph_addr == ERR_ENABLE_OFS) begin
        s_nxt.err_enable = hwdata[ERR_W-1:0];
      end else if (s_r.dph_addr == IO_CTRL_OFS) begin
        s_nxt.h_style = hwdata[H_STYLE_BIT];
      end else if (s_r.dph_addr == INT_MASK_OFS) begin
        s_nxt.int_mask = hwdata[INT_W-1:0];
      end
    end
    // Outputs are registered alongside the state
    s_nxt.outs.stream_err_n = ~|(s_nxt.err_status & s_r.err_enable);
    s_nxt.outs.buffer_load_strobe_n = ~trs_sav;
    s_nxt.outs.field_odd_even = s_nxt.f;
    s_nxt.outs.vblank = s_nxt.v;
    if (s_r.h_style) begin
      s_nxt.outs.hblank = trs_hit ? vin.data[XYZ_H_BIT] : s_r.h_bit;
    end else begin
      s_nxt.outs.hblank = s_nxt.h_blank;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '{w1: 10'h000, w2: 10'h000, w3: 10'h000, f: 1'b0, v: 1'b0,
               h_bit: 1'b0, h_blank: 1'b0, sav_cnt: 2'h0,
               err_status: '0, err_enable: ERR_ENABLE_RST, h_style: 1'b0,
               int_status: '0, int_mask: INT_MASK_RST, dph_wr: 1'b0,
               dph_addr: 8'h00, hrdata: 32'h00000000,
               outs: '{stream_err_n: 1'b1, buffer_load_strobe_n: 1'b1,
                       field_odd_even: 1'b0, vblank: 1'b0, hblank: 1'b0},
               out_oe_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata = s_r.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign status_out = s_r.outs;
  assign out_oe_n = s_r.out_oe_n;
  assign irq = |(s_r.int_status & s_r.int_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_err_flag_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    err_new |=> !status_out.stream_err_n)
    else $error("enabled error did not pull the error flag low");

  a_err_flag_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!status_out.stream_err_n && !field_start && !err_rd_clr) |=> !status_out.stream_err_n)
    else $error("error flag released without field start or read");

  a_err_flag_clean: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (err_rd_clr && err_event == '0) |=> status_out.stream_err_n)
    else $error("error flag low after clearing read with no error");

  a_err_masked: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_r.err_status == '0 && (err_event & s_r.err_enable) == '0)
      |=> status_out.stream_err_n)
    else $error("masked error reached the error flag");

  a_load_strobe: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trs_sav |=> !status_out.buffer_load_strobe_n ##1 status_out.buffer_load_strobe_n)
    else $error("load strobe not exactly one cycle low at start of video");

  a_field_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trs_hit |=> status_out.field_odd_even == $past(vin.data[XYZ_F_BIT]))
    else $error("field output does not follow reference field bit");

  a_vblank_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trs_hit |=> status_out.vblank == $past(vin.data[XYZ_V_BIT]))
    else $error("vertical blanking output does not follow reference bit");

  a_hblank_style0: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!s_r.h_style && trs_sav) |=> status_out.hblank)
    else $error("horizontal output low on start reference in style 0");

  a_hblank_style1: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_r.h_style && trs_hit) |=> status_out.hblank == $past(vin.data[XYZ_H_BIT]))
    else $error("horizontal output does not follow reference bit in style 1");

  a_strobe_rest: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !trs_sav |=> status_out.buffer_load_strobe_n)
    else $error("load strobe low without start of video");

  a_field_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (trs_hit && !vin.data[XYZ_F_BIT]) |=> !status_out.field_odd_even)
    else $error("field output high in field 1");

  a_field_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !trs_hit |=> $stable(status_out.field_odd_even))
    else $error("field output changed between references");

  a_vblank_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (trs_hit && !vin.data[XYZ_V_BIT]) |=> !status_out.vblank)
    else $error("vertical blanking output high outside blanking");

  a_vblank_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !trs_hit |=> $stable(status_out.vblank))
    else $error("vertical blanking output changed between references");

  a_hblank_eav: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!s_r.h_style && trs_eav) |=> status_out.hblank)
    else $error("horizontal output low on end reference in style 0");

  a_hblank_tail: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!s_r.h_style && vin.valid && !trs_hit && s_r.sav_cnt != 2'h0) |=> status_out.hblank)
    else $error("horizontal output dropped inside start reference");

  a_hblank_active: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!s_r.h_style && vin.valid && !trs_hit && s_r.sav_cnt == 2'h0 && !s_r.h_bit)
      |=> !status_out.hblank)
    else $error("horizontal output high in active video in style 0");

  a_hblank_s1_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_r.h_style && !trs_hit) |=> status_out.hblank == $past(s_r.h_bit))
    else $error("horizontal output left reference bit in style 1");

  a_style_wr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_r.dph_wr && s_r.dph_addr == IO_CTRL_OFS)
      |=> (s_r.h_style == $past(hwdata[H_STYLE_BIT])))
    else $error("style select write did not land");

  a_oe_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !out_oe_n |=> !out_oe_n)
    else $error("status pins released outside reset");

  // ----------------------------------------------------------------
  // Error status, register bus and interrupts
  // ----------------------------------------------------------------
  a_err_recorded: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (err_event != '0) |=> ((s_r.err_status & $past(err_event)) == $past(err_event)))
    else $error("error event not recorded in error status");

  a_err_read_clr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    err_rd_clr |=> (s_r.err_status == $past(err_event)))
    else $error("status read did not clear the error status");

  a_err_field_clr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (field_start && err_event == '0) |=> status_out.stream_err_n)
    else $error("error flag still low after field start");

  a_err_enable_wr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_r.dph_wr && s_r.dph_addr == ERR_ENABLE_OFS)
      |=> (s_r.err_enable == $past(hwdata[ERR_W-1:0])))
    else $error("error enable write did not land");

  a_read_data: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_hit |=> (hrdata == $past(rd_val)))
    else $error("read data does not match addressed register");

  a_rdata_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !rd_hit |=> $stable(hrdata))
    else $error("read data changed without a read");

  a_int_err: assert property (
    @(posedge hclk) disable iff (!hresetn)
    err_new |=> s_r.int_status[INT_ERR_BIT])
    else $error("enabled error did not set its interrupt bit");

  a_int_field: assert property (
    @(posedge hclk) disable iff (!hresetn)
    field_start |=> s_r.int_status[INT_FIELD_BIT])
    else $error("field start did not set its interrupt bit");

  a_int_sav: assert property (
    @(posedge hclk) disable iff (!hresetn)
    trs_sav |=> s_r.int_status[INT_SAV_BIT])
    else $error("start of video did not set its interrupt bit");

  a_int_read_clr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (int_rd_clr && int_set == '0) |=> (s_r.int_status == '0))
    else $error("status read did not clear interrupt status");

  a_mask_wr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_r.dph_wr && s_r.dph_addr == INT_MASK_OFS)
      |=> (s_r.int_mask == $past(hwdata[INT_W-1:0])))
    else $error("interrupt mask write did not land");

endmodule : vid_status_out
`default_nettype wire

// *** verilog/vid_status_pkg.sv ***
// Constants, layouts and carrier types for the video timing status outputs
// Function
// - Error flag goes low when any enabled recorded error bit is set.
// - Flag stays low until next frame or field start, or status read.
// - Error flag stays high while the stream arrives without errors.
// - Only enabled error bits count; all enabled after reset.
// - Load strobe rests high, pulses low one clock at start of active video.
// - Field output high throughout field 2, from the timing reference field bit.
// - Field output low in field 1 and in progressive formats.
// - Vertical blanking output follows the timing reference vertical bit.
// - Vertical blanking output low outside vertical blanking.
// - Horizontal output style chosen by one host-writable control bit.
// - Style 0: high over whole horizontal blanking including both reference words.
// - Under reset everything returns to defaults and outputs float.
package vid_status_pkg;

  // ----------------------------------------------------------------
  // Widths and timing reference codes
  // ----------------------------------------------------------------
  localparam int ERR_W = 5;
  localparam int INT_W = 3;
  localparam logic [9:0] TRS_PRE1 = 10'h3ff;
  localparam logic [9:0] TRS_PRE0 = 10'h000;
  localparam int XYZ_F_BIT = 8;
  localparam int XYZ_V_BIT = 7;
  localparam int XYZ_H_BIT = 6;
  localparam logic [1:0] SAV_TAIL = 2'h3;

  // ----------------------------------------------------------------
  // Register offsets, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ERR_STATUS_OFS = 8'h00;
  localparam logic [7:0] ERR_ENABLE_OFS = 8'h04;
  localparam logic [7:0] IO_CTRL_OFS = 8'h08;
  localparam logic [7:0] INT_STATUS_OFS = 8'h0c;
  localparam logic [7:0] INT_MASK_OFS = 8'h10;
  localparam logic [7:0] TIMING_OFS = 8'h14;
  localparam int H_STYLE_BIT = 0;
  localparam int INT_ERR_BIT = 0;
  localparam int INT_FIELD_BIT = 1;
  localparam int INT_SAV_BIT = 2;
  localparam logic [ERR_W-1:0] ERR_ENABLE_RST = 5'h1f;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [9:0] data;
  } vid_word_type;

  typedef struct packed {
    logic stream_err_n;
    logic buffer_load_strobe_n;
    logic field_odd_even;
    logic vblank;
    logic hblank;
  } status_out_type;

  typedef struct packed {
    logic [9:0] w1;
    logic [9:0] w2;
    logic [9:0] w3;
    logic f;
    logic v;
    logic h_bit;
    logic h_blank;
    logic [1:0] sav_cnt;
    logic [ERR_W-1:0] err_status;
    logic [ERR_W-1:0] err_enable;
    logic h_style;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] hrdata;
    status_out_type outs;
    logic out_oe_n;
  } state_type;

endpackage : vid_status_pkg
